/* File: logic/dma_event_cfg.svh */
`ifndef DMA_EVENT_CFG_SVH
`define DMA_EVENT_CFG_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define ADDR_EVENT_CONTROL 4'h0
`define ADDR_CELL_SIZE 4'h4
`define ADDR_CELL_POINTER 4'h8
`define ADDR_CHANNEL_CTRL 4'hc
`define ADDR_INT_STATUS 5'h10
`define ADDR_INT_MASK 5'h14
`define ADDR_WIDTH 5

// ************************************************************
// Event control field positions
// ************************************************************
`define EC_ABORT_IRQ_HI 23
`define EC_ABORT_IRQ_LO 16
`define EC_START_IRQ_HI 15
`define EC_START_IRQ_LO 8
`define EC_FORCE_BIT 7
`define EC_SW_ABORT_BIT 6
`define EC_PAT_EN_BIT 5
`define EC_START_EN_BIT 4
`define EC_ABORT_EN_BIT 3

// ************************************************************
// Reset values
// ************************************************************
`define RESET_IRQ_SELECT 8'hff
`define RESET_CELL_SIZE 16'h0000

// ************************************************************
// Interrupt status bit positions
// ************************************************************
`define INT_ABORT_BIT 0
`define INT_CELL_DONE_BIT 1
`define INT_BITS 2

// ************************************************************
// AXI responses
// ************************************************************
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: logic/dma_event_pkg.sv */
package dma_event_pkg;

	// Event control fields as stored
	typedef struct packed {
		logic [7:0] abort_irq_select;
		logic [7:0] start_irq_select;
		logic pattern_abort_enable;
		logic start_irq_enable;
		logic abort_irq_enable;
	} event_ctrl_type;

	// Channel transfer states, Gray along idle -> busy -> done
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_busy = 2'b01,
		st_done = 2'b11
	} chan_state_type;

	// Byte progress from the data mover
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} byte_beat_type;

endpackage

/* File: logic/irq_match.sv */
`timescale 1ns/1ps
`include "dma_event_cfg.svh"

// One-hot request vector matched against a selected number
module irq_match #(
	parameter int IRQ_COUNT = 256
) (
	// Requests
	input wire logic [IRQ_COUNT-1:0] irq_lines,
	// Selection
	input wire logic [7:0] select,
	input wire logic enable,
	// Result
	output logic hit
);

	// Refuse sizes that the 8-bit select cannot span, at elaboration
	generate
		if (IRQ_COUNT < 1 || IRQ_COUNT > 256)
		begin : g_bad_size
			$error("irq_match: IRQ_COUNT out of range");
		end
	endgenerate

	// Per-line compare, one generate loop
	logic [IRQ_COUNT-1:0] line_hit;
	genvar i;
	generate
		for (i = 0; i < IRQ_COUNT; i++)
		begin : g_line
			assign line_hit[i] = irq_lines[i] && (select == 8'(i));
		end
	endgenerate

	// Disabled selection is ignored entirely
	assign hit = enable && (|line_hit);

endmodule

/* File: logic/pattern_detect.sv */
`timescale 1ns/1ps
`include "dma_event_cfg.svh"

// Compares moved bytes to the pattern value when enabled
module pattern_detect (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic enable,
	input wire logic [7:0] pattern_value,
	// Byte stream
	input wire dma_event_pkg::byte_beat_type beat,
	// Result, high for one cycle after each matching byte
	output logic match
);

	// Registered match; no compare while disabled
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			match <= 1'b0;
		else
			match <= enable && beat.valid && (beat.data == pattern_value);
	end

endmodule

/* File: logic/dma_event_ctrl.sv */
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "dma_event_cfg.svh"

module dma_event_ctrl #(
	parameter int IRQ_COUNT = 256
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [`ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [`ADDR_WIDTH-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Peripheral interrupt requests
	input wire logic [IRQ_COUNT-1:0] irq_lines,
	// Byte stream from the data mover
	input wire dma_event_pkg::byte_beat_type beat,
	// Channel status to the data mover
	output logic transfer_active,
	output logic channel_on,
	output logic channel_abort_flag,
	// Interrupt
	output logic irq
);

	// ************************************************************
	// Storage
	// ************************************************************
	dma_event_pkg::event_ctrl_type ctrl; // Event control fields
	logic [15:0] cell_size; // Bytes per start event
	logic [15:0] cell_pointer; // Bytes moved in cell
	logic [7:0] pattern_value; // Match byte
	logic [`INT_BITS-1:0] int_status; // Sticky events
	logic [`INT_BITS-1:0] int_mask; // Interrupt enables
	dma_event_pkg::chan_state_type state; // Transfer state
	logic [`ADDR_WIDTH-1:0] aw_addr; // Captured write address
	logic [31:0] w_data; // Captured write data
	logic [3:0] w_strb; // Captured strobes
	logic aw_held; // Write address taken
	logic w_held; // Write data taken

	// ************************************************************
	// Write channel
	// ************************************************************
	logic wr_go; // Both halves present
	logic wr_hit; // Decoded
	assign wr_go = aw_held && w_held && !s_axi_bvalid;
	assign wr_hit = (aw_addr == 5'(`ADDR_EVENT_CONTROL)) || (aw_addr == 5'(`ADDR_CELL_SIZE))
		|| (aw_addr == 5'(`ADDR_CELL_POINTER)) || (aw_addr == 5'(`ADDR_CHANNEL_CTRL))
		|| (aw_addr == `ADDR_INT_STATUS) || (aw_addr == `ADDR_INT_MASK);

	// Address and data accepted in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			else if (wr_go)
				aw_held <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			else if (wr_go)
				w_held <= 1'b0;
		end
	end

	// Write response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Per-register write strobes
	logic wr_ec;
	logic wr_cs;
	logic wr_cc;
	logic wr_is;
	logic wr_im;
	assign wr_ec = wr_go && (aw_addr == 5'(`ADDR_EVENT_CONTROL));
	assign wr_cs = wr_go && (aw_addr == 5'(`ADDR_CELL_SIZE));
	assign wr_cc = wr_go && (aw_addr == 5'(`ADDR_CHANNEL_CTRL));
	assign wr_is = wr_go && (aw_addr == `ADDR_INT_STATUS);
	assign wr_im = wr_go && (aw_addr == `ADDR_INT_MASK);

	// ************************************************************
	// Event decode
	// ************************************************************
	logic start_hit;
	logic abort_hit;
	logic pattern_hit;
	logic force_req;
	logic sw_abort_req;
	logic abort_any;
	logic start_any;
	logic cell_end;

	// Start number compare, gated by enable
	irq_match #(.IRQ_COUNT(IRQ_COUNT)) u_start_match (
		.irq_lines(irq_lines),
		.select(ctrl.start_irq_select),
		.enable(ctrl.start_irq_enable),
		.hit(start_hit)
	);

	// Abort number compare, gated by enable
	irq_match #(.IRQ_COUNT(IRQ_COUNT)) u_abort_match (
		.irq_lines(irq_lines),
		.select(ctrl.abort_irq_select),
		.enable(ctrl.abort_irq_enable),
		.hit(abort_hit)
	);

	// Pattern compare only runs while enabled
	pattern_detect u_pattern (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(ctrl.pattern_abort_enable && state == dma_event_pkg::st_busy),
		.pattern_value(pattern_value),
		.beat(beat),
		.match(pattern_hit)
	);

	// Write-one pulses; nothing is stored
	assign force_req = wr_ec && w_strb[0] && w_data[`EC_FORCE_BIT];
	assign sw_abort_req = wr_ec && w_strb[0] && w_data[`EC_SW_ABORT_BIT];
	assign abort_any = abort_hit || sw_abort_req || pattern_hit;
	assign start_any = (start_hit || force_req) && channel_on;
	assign cell_end = beat.valid && (cell_pointer + 16'h0001 >= cell_size);

	// ************************************************************
	// Register updates
	// ************************************************************
	// Event control fields, byte-lane writes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl.abort_irq_select <= `RESET_IRQ_SELECT;
			ctrl.start_irq_select <= `RESET_IRQ_SELECT;
			ctrl.pattern_abort_enable <= 1'b0;
			ctrl.start_irq_enable <= 1'b0;
			ctrl.abort_irq_enable <= 1'b0;
		end
		else if (wr_ec)
		begin
			if (w_strb[2])
				ctrl.abort_irq_select <= w_data[`EC_ABORT_IRQ_HI:`EC_ABORT_IRQ_LO];
			if (w_strb[1])
				ctrl.start_irq_select <= w_data[`EC_START_IRQ_HI:`EC_START_IRQ_LO];
			if (w_strb[0])
			begin
				ctrl.pattern_abort_enable <= w_data[`EC_PAT_EN_BIT];
				ctrl.start_irq_enable <= w_data[`EC_START_EN_BIT];
				ctrl.abort_irq_enable <= w_data[`EC_ABORT_EN_BIT];
			end
		end
	end

	// Cell size; upper half dropped
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cell_size <= `RESET_CELL_SIZE;
		else if (wr_cs)
		begin
			if (w_strb[0])
				cell_size[7:0] <= w_data[7:0];
			if (w_strb[1])
				cell_size[15:8] <= w_data[15:8];
		end
	end

	// Channel on and pattern byte
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			channel_on <= 1'b0;
			pattern_value <= 8'h00;
		end
		else
		begin
			if (wr_cc && w_strb[1])
				pattern_value <= w_data[15:8];
			if (pattern_hit)
				channel_on <= 1'b0;
			else if (wr_cc && w_strb[0])
				channel_on <= w_data[0];
		end
	end

	// Transfer state machine
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state <= dma_event_pkg::st_idle;
		else
			case (state)
				dma_event_pkg::st_idle:
					if (start_any && !abort_any)
						state <= dma_event_pkg::st_busy;
				dma_event_pkg::st_busy:
					if (abort_any)
						state <= dma_event_pkg::st_idle;
					else if (cell_end)
						state <= dma_event_pkg::st_done;
				dma_event_pkg::st_done:
					state <= dma_event_pkg::st_idle;
				default:
					state <= dma_event_pkg::st_idle;
			endcase
	end

	// Cell pointer: counts bytes, cleared on start or pattern
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cell_pointer <= 16'h0000;
		else if (pattern_hit)
			cell_pointer <= 16'h0000;
		else if (state != dma_event_pkg::st_busy && start_any)
			cell_pointer <= 16'h0000;
		else if (state == dma_event_pkg::st_busy && beat.valid)
			cell_pointer <= cell_pointer + 16'h0001;
	end

	// Status outputs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			transfer_active <= 1'b0;
		else
			transfer_active <= (state == dma_event_pkg::st_busy) && !abort_any && !cell_end;
	end

	// ************************************************************
	// Interrupt status, mask and output
	// ************************************************************
	logic [`INT_BITS-1:0] int_event;
	assign int_event[`INT_ABORT_BIT] = (state == dma_event_pkg::st_busy) && abort_any;
	assign int_event[`INT_CELL_DONE_BIT] = (state == dma_event_pkg::st_busy) && !abort_any
		&& cell_end;

	// Sticky bits; a new event beats a write-one clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			int_status <= '0;
		else if (wr_is && w_strb[0])
			int_status <= (int_status & ~w_data[`INT_BITS-1:0]) | int_event;
		else
			int_status <= int_status | int_event;
	end

	// Mask register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			int_mask <= '0;
		else if (wr_im && w_strb[0])
			int_mask <= w_data[`INT_BITS-1:0];
	end

	// Interrupt and abort flag from flops
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq <= 1'b0;
			channel_abort_flag <= 1'b0;
		end
		else
		begin
			irq <= |(int_status & int_mask);
			channel_abort_flag <= int_status[`INT_ABORT_BIT];
		end
	end

	// ************************************************************
	// Read channel
	// ************************************************************
	logic [31:0] rd_word;

	// Read mux; unused bits are zero
	always_comb
	begin
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			5'(`ADDR_EVENT_CONTROL):
				rd_word = {8'h00, ctrl.abort_irq_select, ctrl.start_irq_select, 2'b00,
					ctrl.pattern_abort_enable, ctrl.start_irq_enable,
					ctrl.abort_irq_enable, 3'b000};
			5'(`ADDR_CELL_SIZE):
				rd_word = {16'h0000, cell_size};
			5'(`ADDR_CELL_POINTER):
				rd_word = {16'h0000, cell_pointer};
			5'(`ADDR_CHANNEL_CTRL):
				rd_word = {16'h0000, pattern_value, 7'h00, channel_on};
			`ADDR_INT_STATUS:
				rd_word = {30'h0, int_status};
			`ADDR_INT_MASK:
				rd_word = {30'h0, int_mask};
			default:
				rd_word = 32'h0000_0000;
		endcase
	end

	// One-cycle read answer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= (s_axi_araddr[1:0] == 2'b00 && s_axi_araddr <= `ADDR_INT_MASK)
					? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	abort_ends_busy_a: assert property ((state == dma_event_pkg::st_busy && abort_any)
		|=> state == dma_event_pkg::st_idle) else $error("abort left busy");
	start_needs_enable_a: assert property ((state == dma_event_pkg::st_idle && !force_req
		&& !ctrl.start_irq_enable) |=> state != dma_event_pkg::st_busy)
		else $error("start without enable");
	force_starts_a: assert property ((state == dma_event_pkg::st_idle && force_req
		&& channel_on && !abort_any) |=> state == dma_event_pkg::st_busy)
		else $error("force ignored");
	sw_abort_works_a: assert property ((state == dma_event_pkg::st_busy && sw_abort_req)
		|=> !transfer_active) else $error("software abort ignored");
	pattern_off_a: assert property (!ctrl.pattern_abort_enable |=> !pattern_hit)
		else $error("pattern match while disabled");
	pattern_clears_a: assert property (pattern_hit
		|=> !channel_on && cell_pointer == 16'h0000) else $error("pattern did not clear");
	abort_flag_sets_a: assert property ((state == dma_event_pkg::st_busy && abort_hit)
		|-> ##2 channel_abort_flag) else $error("abort flag not set");
	size_upper_zero_a: assert property (s_axi_rvalid
		&& $past(s_axi_araddr) == 5'(`ADDR_CELL_SIZE) |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("size upper bits nonzero");
	pointer_counts_a: assert property ((state == dma_event_pkg::st_busy && beat.valid
		&& !pattern_hit) |=> cell_pointer == $past(cell_pointer) + 16'h0001)
		else $error("pointer did not count");
	ec_low_zero_a: assert property (s_axi_rvalid
		&& $past(s_axi_araddr) == 5'(`ADDR_EVENT_CONTROL) |-> s_axi_rdata[31:24] == 8'h00
		&& s_axi_rdata[7:6] == 2'b00 && s_axi_rdata[2:0] == 3'b000)
		else $error("event control reserved bits nonzero");

	cover_start_c: cover property (state == dma_event_pkg::st_idle
		##1 state == dma_event_pkg::st_busy);
	cover_done_c: cover property (state == dma_event_pkg::st_done);
	cover_abort_c: cover property (state == dma_event_pkg::st_busy && abort_hit);
	cover_irq_c: cover property (irq);

endmodule

/* File: dv/dma_far_side.sv */
`timescale 1ns/1ps

// Peripherals raising requests and the data mover handing over bytes
module dma_far_side #(
	parameter int IRQ_COUNT = 256
) (
	// Clock
	input wire logic aclk,
	// Requests and bytes towards the channel
	output logic [IRQ_COUNT-1:0] irq_lines,
	output dma_event_pkg::byte_beat_type beat
);
	// ************************************************************
	// Far side behaviour
	// ************************************************************
	// Quiet lines at time zero
	initial
	begin
		irq_lines = '0;
		beat = '0;
	end

	// One-cycle request on a single line
	task automatic pulse(input int n);
		@(posedge aclk);
		irq_lines[n] <= 1'b1;
		@(posedge aclk);
		irq_lines <= '0;
	endtask

	// Bytes on back-to-back cycles; idle data inverted so it is never stale
	task automatic send(input int n, input logic [7:0] d);
		repeat (n)
		begin
			@(posedge aclk);
			beat <= '{valid: 1'b1, data: d};
		end
		@(posedge aclk);
		beat <= '{valid: 1'b0, data: ~d};
	endtask
endmodule

/* File: dv/dma_channel_event_control_tb.sv */
`timescale 1ns/1ps
`include "dma_event_cfg.svh"

// Self-checking bench for the channel event logic
module dma_channel_event_control_tb;
	// Clock and reset
	logic aclk;
	logic aresetn;
	// Register bus
	logic [4:0] s_axi_awaddr;
	logic s_axi_awvalid;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic s_axi_wvalid;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready;
	logic [4:0] s_axi_araddr;
	logic s_axi_arvalid;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready;
	// Far side and status
	logic [255:0] irq_lines;
	dma_event_pkg::byte_beat_type beat;
	logic transfer_active;
	logic channel_on;
	logic channel_abort_flag;
	logic irq;
	// Score
	int err_total;
	int comparisons;

	// ************************************************************
	// Instances
	// ************************************************************
	dma_event_ctrl #(.IRQ_COUNT(256)) uut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_lines(irq_lines),
		.beat(beat), .transfer_active(transfer_active), .channel_on(channel_on),
		.channel_abort_flag(channel_abort_flag), .irq(irq));
	dma_far_side #(.IRQ_COUNT(256)) far (.aclk(aclk), .irq_lines(irq_lines), .beat(beat));

	// ************************************************************
	// Helpers
	// ************************************************************
	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic give_verdict();
		if (err_total == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Event control word from its fields
	function automatic logic [31:0] ev(input logic [7:0] a, input logic [7:0] s,
		input logic [7:0] b);
		return {8'h00, a, s, b};
	endfunction

	// Bus write, address and data offered together
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw;
		logic w;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		do
		begin
			@(posedge aclk);
			if (aw && s_axi_awready === 1'b1)
			begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready === 1'b1)
			begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check(s_axi_bresp, er);
	endtask

	// Bus read compared against an expected word and response
	task automatic rchk(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		check(s_axi_rresp, er);
		if (er == `RESP_OKAY)
			check(s_axi_rdata, exp);
	endtask

	// Bounded wait for the transfer state
	task automatic wait_active(input logic v);
		int n;
		n = 0;
		while (transfer_active !== v && n < 50)
		begin
			@(posedge aclk);
			n++;
		end
		check(transfer_active, v);
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	// Reset values, read-only and unimplemented bits, unmapped place
	task automatic t_regs();
		rchk(`ADDR_EVENT_CONTROL, 32'h00ffff00, `RESP_OKAY);
		rchk(`ADDR_CELL_SIZE, 32'h0, `RESP_OKAY);
		rchk(`ADDR_CELL_POINTER, 32'h0, `RESP_OKAY);
		wr(`ADDR_EVENT_CONTROL, 32'hffffffff, `RESP_OKAY);
		rchk(`ADDR_EVENT_CONTROL, 32'h00ffff38, `RESP_OKAY);
		wr(`ADDR_CELL_SIZE, 32'hffffffff, `RESP_OKAY);
		rchk(`ADDR_CELL_SIZE, 32'h0000ffff, `RESP_OKAY);
		wr(`ADDR_CELL_POINTER, 32'hffff1234, `RESP_OKAY);
		rchk(`ADDR_CELL_POINTER, 32'h0, `RESP_OKAY);
		wr(5'h18, 32'h1, `RESP_SLVERR);
		rchk(5'h1c, 32'h0, `RESP_SLVERR);
		wr(`ADDR_EVENT_CONTROL, 32'h00ffff00, `RESP_OKAY);
	endtask

	// Forced cell with a stall in mid-cell
	task automatic t_force_cell();
		wr(`ADDR_CHANNEL_CTRL, 32'h1, `RESP_OKAY);
		wr(`ADDR_CELL_SIZE, 32'h4, `RESP_OKAY);
		wr(`ADDR_EVENT_CONTROL, ev(8'hff, 8'hff, 8'h80), `RESP_OKAY);
		wait_active(1'b1);
		far.send(2, 8'h11);
		rchk(`ADDR_CELL_POINTER, 32'h2, `RESP_OKAY);
		far.send(2, 8'h22);
		wait_active(1'b0);
		rchk(`ADDR_INT_STATUS, 32'h2, `RESP_OKAY);
		wr(`ADDR_INT_STATUS, 32'h3, `RESP_OKAY);
	endtask

	// Start requests gated by the enable, across the number range
	task automatic t_start_irq();
		logic [7:0] nums [3];
		nums = '{8'h00, 8'h7f, 8'hff};
		foreach (nums[i])
		begin
			wr(`ADDR_EVENT_CONTROL, ev(8'hff, nums[i], 8'h00), `RESP_OKAY);
			far.pulse(nums[i]);
			repeat (5) @(posedge aclk);
			check(transfer_active, 1'b0);
			wr(`ADDR_EVENT_CONTROL, ev(8'hff, nums[i], 8'h10), `RESP_OKAY);
			far.pulse(nums[i] ^ 8'h01);
			repeat (5) @(posedge aclk);
			check(transfer_active, 1'b0);
			far.pulse(nums[i]);
			wait_active(1'b1);
			wr(`ADDR_EVENT_CONTROL, ev(8'hff, nums[i], 8'h40), `RESP_OKAY);
			wait_active(1'b0);
			wr(`ADDR_INT_STATUS, 32'h3, `RESP_OKAY);
		end
	endtask

	// Abort request gated by its enable; status, mask and interrupt
	task automatic t_abort_irq();
		wr(`ADDR_INT_MASK, 32'h1, `RESP_OKAY);
		wr(`ADDR_EVENT_CONTROL, ev(8'h33, 8'hff, 8'h80), `RESP_OKAY);
		wait_active(1'b1);
		far.pulse(8'h33);
		repeat (5) @(posedge aclk);
		check(transfer_active, 1'b1);
		check(channel_abort_flag, 1'b0);
		wr(`ADDR_EVENT_CONTROL, ev(8'h33, 8'hff, 8'h08), `RESP_OKAY);
		far.pulse(8'h33);
		wait_active(1'b0);
		repeat (2) @(posedge aclk);
		check(channel_abort_flag, 1'b1);
		check(irq, 1'b1);
		wr(`ADDR_INT_MASK, 32'h0, `RESP_OKAY);
		repeat (2) @(posedge aclk);
		check(irq, 1'b0);
		wr(`ADDR_INT_MASK, 32'h1, `RESP_OKAY);
		repeat (2) @(posedge aclk);
		check(irq, 1'b1);
		wr(`ADDR_INT_STATUS, 32'h1, `RESP_OKAY);
		repeat (2) @(posedge aclk);
		check(channel_abort_flag, 1'b0);
		check(irq, 1'b0);
	endtask

	// Pattern byte with the match enabled, then with it disabled
	task automatic t_pattern();
		wr(`ADDR_CHANNEL_CTRL, 32'h5a01, `RESP_OKAY);
		wr(`ADDR_CELL_SIZE, 32'h8, `RESP_OKAY);
		wr(`ADDR_EVENT_CONTROL, ev(8'hff, 8'hff, 8'ha0), `RESP_OKAY);
		wait_active(1'b1);
		far.send(3, 8'h11);
		far.send(1, 8'h5a);
		wait_active(1'b0);
		check(channel_on, 1'b0);
		rchk(`ADDR_CELL_POINTER, 32'h0, `RESP_OKAY);
		wr(`ADDR_INT_STATUS, 32'h3, `RESP_OKAY);
		wr(`ADDR_CHANNEL_CTRL, 32'h5a01, `RESP_OKAY);
		wr(`ADDR_EVENT_CONTROL, ev(8'hff, 8'hff, 8'h80), `RESP_OKAY);
		wait_active(1'b1);
		far.send(3, 8'h11);
		far.send(1, 8'h5a);
		repeat (4) @(posedge aclk);
		check(transfer_active, 1'b1);
		check(channel_on, 1'b1);
		rchk(`ADDR_CELL_POINTER, 32'h4, `RESP_OKAY);
		wr(`ADDR_EVENT_CONTROL, ev(8'hff, 8'hff, 8'h40), `RESP_OKAY);
		wait_active(1'b0);
	endtask

	// ************************************************************
	// Clock, watchdog and main sequence
	// ************************************************************
	// 100 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// Cuts a hang short
	initial
	begin
		repeat (5000) @(posedge aclk);
		err_total++;
		give_verdict();
	end

	// Reset, then every scenario in turn
	initial
	begin
		err_total = 0;
		comparisons = 0;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_force_cell();
		t_start_irq();
		t_abort_irq();
		t_pattern();
		give_verdict();
	end
endmodule
